// file: verilog/csc_consts.vh
// constants of the chip-level configuration register space
// assumes byte-wide index/data port accesses from the host bus decoder
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// register indices
`define CSC_IDX_UNIT_SEL 8'h07
`define CSC_IDX_CFG_LO 8'h26
`define CSC_IDX_CFG_HI 8'h27
`define CSC_IDX_TEST_F 8'h2A
`define CSC_IDX_TEST_D 8'h2B
`define CSC_IDX_TEST_KBD 8'h2C
`define CSC_IDX_TEST_A 8'h2D
`define CSC_IDX_TEST_B 8'h2E
`define CSC_IDX_TEST_C 8'h2F
`define CSC_IDX_UNIT_FIRST 8'h30
`define CSC_IDX_UNIT_ACT 8'h30

// field positions
`define CSC_KBD_RST_BIT 6
`define CSC_ACT_BIT 0

// reset values
`define CSC_TEST_RST 8'h00
`define CSC_CFG_LO_STRAP0 8'h2E
`define CSC_CFG_LO_STRAP1 8'h4E
`define CSC_CFG_HI_RST 8'h00
`define CSC_UNIT_SEL_RST 3'h0
`define CSC_INDEX_RST 8'h00

`endif

// file: verilog/csc_config_space.v
// chip-level configuration space: relocatable index/data ports, test registers,
// keyboard core reset, unit select and per-unit activation banks.
// assumes io strobes come from a bus decoder on clk_i, one cycle each.
`timescale 1ns/100ps
`default_nettype none

`include "csc_consts.vh"

// Summary of operation
// - bit 6 at index 2C holds keyboard core in reset while one.
// - configuration port address always even; bit 0 forced zero.
// - new port address decoded immediately after high byte write.
// - low byte written first; relocation applied on high byte write.
// - port address reset only by hard reset or main-supply power-on.
// - default port address 02E or 04E from sampled strap pin.
// - per-unit registers live at indices 30 to FF.
// - eight per-unit banks, chosen by unit select at index 07.
// - index port write selects register; data port accesses it.
// - per-unit registers reachable only in configuration state.
// - index 26 holds address bits 7..1, index 27 bits 15..8.
// - activation bit 0 enables or disables the selected unit.
module csc_config_space (
  // clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire main_por_i,
  input wire standby_supply_por_i,
  input wire soft_rst_i,
  // strap and state
  input wire cfg_strap_i,
  input wire config_mode_i,
  // host io access
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [15:0] io_addr_i,
  input wire [7:0] io_wdata_i,
  output reg [7:0] io_rdata_o,
  output reg io_hit_o,
  // block controls
  output reg [15:0] config_base_o,
  output reg kbd_core_reset_o,
  output reg [7:0] unit_active_o
);

  ////////////////////////////////////////////////////////////////////////
  // strap synchroniser
  reg strap_meta_r;
  reg strap_sync_r;

  always @(posedge clk_i) begin
    strap_meta_r <= cfg_strap_i;
    strap_sync_r <= strap_meta_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  reg [7:0] index_r;
  reg [7:0] cfg_lo_r;
  reg [7:0] test_f_r;
  reg [7:0] test_d_r;
  reg [7:0] test_kbd_r;
  reg [7:0] test_a_r;
  reg [7:0] test_b_r;
  reg [7:0] test_c_r;
  reg [2:0] unit_sel_r;

  wire hard_rst = rst_i | main_por_i;
  wire por_rst = main_por_i | standby_supply_por_i;
  wire any_rst = hard_rst | standby_supply_por_i | soft_rst_i;

  wire hit_index = (io_addr_i == config_base_o);
  wire hit_data = (io_addr_i == (config_base_o | 16'h0001));
  wire wr_index = io_wr_i & hit_index;
  wire wr_data = io_wr_i & hit_data;
  wire unit_idx = (index_r >= `CSC_IDX_UNIT_FIRST);
  wire unit_ok = unit_idx & config_mode_i;

  // a data-port write aimed at one index; arguments only, so that a
  // continuous assignment that calls it sees every operand change
  function wr_to;
    input strobe;
    input [7:0] cur;
    input [7:0] idx;
    begin
      wr_to = strobe & (cur == idx);
    end
  endfunction

  // default low address byte from the strap level
  function [7:0] dflt_lo;
    input strap;
    begin
      dflt_lo = strap ? `CSC_CFG_LO_STRAP1 : `CSC_CFG_LO_STRAP0;
    end
  endfunction

  // per-register write strobes, decoded once
  wire wr_cfg_lo = wr_to(wr_data, index_r, `CSC_IDX_CFG_LO);
  wire wr_cfg_hi = wr_to(wr_data, index_r, `CSC_IDX_CFG_HI);
  wire wr_test_f = wr_to(wr_data, index_r, `CSC_IDX_TEST_F);
  wire wr_test_d = wr_to(wr_data, index_r, `CSC_IDX_TEST_D);
  wire wr_test_kbd = wr_to(wr_data, index_r, `CSC_IDX_TEST_KBD);
  wire wr_test_a = wr_to(wr_data, index_r, `CSC_IDX_TEST_A);
  wire wr_test_b = wr_to(wr_data, index_r, `CSC_IDX_TEST_B);
  wire wr_test_c = wr_to(wr_data, index_r, `CSC_IDX_TEST_C);
  wire wr_unit_sel = wr_to(wr_data, index_r, `CSC_IDX_UNIT_SEL);
  wire wr_unit_act = wr_to(wr_data, index_r, `CSC_IDX_UNIT_ACT) & unit_ok;

  ////////////////////////////////////////////////////////////////////////
  // index port
  always @(posedge clk_i) begin
    if (any_rst) begin
      index_r <= `CSC_INDEX_RST;
    end else if (wr_index) begin
      index_r <= io_wdata_i;
    end
  end

  // only hard reset or main power-on
  always @(posedge clk_i) begin
    if (hard_rst) begin
      cfg_lo_r <= dflt_lo(strap_sync_r);
      config_base_o <= {`CSC_CFG_HI_RST, dflt_lo(strap_sync_r)};
    end else begin
      if (wr_cfg_lo) begin
        cfg_lo_r <= {io_wdata_i[7:1], 1'b0};
      end
      if (wr_cfg_hi) begin
        config_base_o <= {io_wdata_i, cfg_lo_r};
      end
    end
  end

  always @(posedge clk_i) begin
    if (por_rst) begin
      test_f_r <= `CSC_TEST_RST;
      test_d_r <= `CSC_TEST_RST;
      test_kbd_r <= `CSC_TEST_RST;
      test_a_r <= `CSC_TEST_RST;
      test_b_r <= `CSC_TEST_RST;
      test_c_r <= `CSC_TEST_RST;
    end else begin
      if (wr_test_f) test_f_r <= io_wdata_i;
      if (wr_test_d) test_d_r <= io_wdata_i;
      if (wr_test_kbd) test_kbd_r <= io_wdata_i;
      if (wr_test_a) test_a_r <= io_wdata_i;
      if (wr_test_b) test_b_r <= io_wdata_i;
      if (wr_test_c) test_c_r <= io_wdata_i;
    end
  end

  // keyboard core reset follows bit 6
  always @(posedge clk_i) begin
    if (por_rst) begin
      kbd_core_reset_o <= 1'b0;
    end else if (wr_test_kbd) begin
      kbd_core_reset_o <= io_wdata_i[`CSC_KBD_RST_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (any_rst) begin
      unit_sel_r <= `CSC_UNIT_SEL_RST;
      unit_active_o <= 8'h00;
    end else begin
      if (wr_unit_sel) begin
        unit_sel_r <= io_wdata_i[2:0];
      end
      if (wr_unit_act) begin
        unit_active_o[unit_sel_r] <= io_wdata_i[`CSC_ACT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the strobe
  reg [7:0] data_mux;

  always @* begin
    case (index_r)
      `CSC_IDX_UNIT_SEL: data_mux = {5'h00, unit_sel_r};
      `CSC_IDX_CFG_LO: data_mux = cfg_lo_r;
      `CSC_IDX_CFG_HI: data_mux = config_base_o[15:8];
      `CSC_IDX_TEST_F: data_mux = test_f_r;
      `CSC_IDX_TEST_D: data_mux = test_d_r;
      `CSC_IDX_TEST_KBD: data_mux = test_kbd_r;
      `CSC_IDX_TEST_A: data_mux = test_a_r;
      `CSC_IDX_TEST_B: data_mux = test_b_r;
      `CSC_IDX_TEST_C: data_mux = test_c_r;
      // unit registers read zero outside config state
      `CSC_IDX_UNIT_ACT: data_mux = {7'h00, unit_ok & unit_active_o[unit_sel_r]};
      default: data_mux = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (any_rst) begin
      io_rdata_o <= 8'h00;
      io_hit_o <= 1'b0;
    end else begin
      io_hit_o <= io_rd_i & (hit_index | hit_data);
      if (io_rd_i & hit_index) begin
        io_rdata_o <= index_r;
      end else if (io_rd_i & hit_data) begin
        io_rdata_o <= data_mux;
      end
    end
  end

endmodule

`default_nettype wire

// file: sim/csc_chk_sva.sv
// port checker of the config space
// assumes binding from the bench top
`timescale 1ns/100ps
`default_nettype none
module csc_chk(
  input wire logic clk_i, rst_i, main_por_i, standby_supply_por_i, soft_rst_i,
  input wire logic config_mode_i, io_wr_i, io_rd_i, io_hit_o, kbd_core_reset_o,
  input wire logic [15:0] io_addr_i, config_base_o,
  input wire logic [7:0] unit_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire pm = io_addr_i == config_base_o || io_addr_i == (config_base_o | 16'h0001);
  wire sr = soft_rst_i || standby_supply_por_i || main_por_i;
  sequence s_rd;
    io_rd_i && pm && !sr;
  endsequence
  a_base_even: assert property (!config_base_o[0]) else $error("odd");
  a_hit_rd: assert property (s_rd |=> io_hit_o) else $error("nohit");
  a_hit_why: assert property (io_hit_o |-> $past(io_rd_i && pm)) else $error("hit");
  a_kbd_why: assert property ($changed(kbd_core_reset_o) |-> $past(io_wr_i || sr))
    else $error("kbd");
  a_base_why: assert property ($changed(config_base_o) |->
    $past(io_wr_i && io_addr_i == (config_base_o | 16'h0001) || main_por_i || rst_i))
    else $error("base");
  a_base_keep: assert property (sr && !main_por_i && !io_wr_i |=>
    $stable(config_base_o)) else $error("keep");
  a_base_dflt: assert property ($fell(rst_i) |->
    config_base_o inside {16'h002E, 16'h004E}) else $error("dflt");
  a_act_cfg: assert property ($changed(unit_active_o) |->
    $past(config_mode_i && io_wr_i || sr)) else $error("act");
endmodule
`default_nettype wire

// file: sim/csc_host.sv
// host model: one-cycle index/data port strobes
// assumes the bench clock; released strobes go low, address and data lines show the inverse
`timescale 1ns/100ps
`default_nettype none
module csc_host(
  input wire logic clk_i,
  output logic io_wr_i, io_rd_i,
  output logic [15:0] io_addr_i,
  output logic [7:0] io_wdata_i
);
  logic [15:0] base = 16'h002E;
  initial {io_wr_i, io_rd_i, io_addr_i, io_wdata_i} = 26'h0;
  task cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 {io_wr_i, io_rd_i, io_addr_i, io_wdata_i} = {w, !w, a, d};
    @(posedge clk_i);
    #1 {io_wr_i, io_rd_i, io_addr_i, io_wdata_i} = {2'b00, ~a, ~d};
  endtask
  task acc(input logic w, input logic [7:0] x, d);
    cyc(1'b1, base, x);
    cyc(w, base | 16'h0001, d);
  endtask
endmodule
`default_nettype wire

// file: sim/csc_config_space_tb_top.sv
// bench top: host model drives the space, reads checked from a queue
// assumes design, host model and checker
`timescale 1ns/100ps
`default_nettype none
module csc_config_space_tb_top;
  logic clk_i = 0, rst_i = 1, main_por_i = 1, standby_supply_por_i = 0, soft_rst_i = 0;
  logic cfg_strap_i = 0, config_mode_i = 0, io_wr_i, io_rd_i, io_hit_o, kbd_core_reset_o;
  logic [15:0] io_addr_i, config_base_o, nb;
  logic [7:0] io_wdata_i, io_rdata_o, unit_active_o, v, q[$];
  int bad_count = 0, n_tests = 0, seed = 39675, i;
  initial forever #10 clk_i = ~clk_i;
  csc_host csc_host_inst(
    .clk_i(clk_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i)
  );
  csc_config_space csc_config_space_inst(
    .clk_i(clk_i), .rst_i(rst_i), .main_por_i(main_por_i),
    .standby_supply_por_i(standby_supply_por_i), .soft_rst_i(soft_rst_i),
    .cfg_strap_i(cfg_strap_i), .config_mode_i(config_mode_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o), .config_base_o(config_base_o),
    .kbd_core_reset_o(kbd_core_reset_o), .unit_active_o(unit_active_o)
  );
  task chk(input string n, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task close_out;
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wx(input logic [7:0] x, d);
    csc_host_inst.acc(1'b1, x, d);
  endtask
  task rx(input logic [7:0] x, e);
    q.push_back(e);
    csc_host_inst.acc(1'b0, x, 8'h00);
  endtask
  always @(negedge clk_i) if (io_hit_o === 1'b1) begin
    if (q.size() == 0) chk("hit", 0, 1);
    else chk("rdata", q.pop_front(), io_rdata_o);
  end
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 {rst_i, main_por_i} = 0;
    chk("base", 16'h002E, config_base_o);
    rx(8'h26, 8'h2E);
    rx(8'h27, 8'h00);
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      wx(8'h2A + 8'(i), v);
      rx(8'h2A + 8'(i), v);
    end
    wx(8'h2C, 8'h40);
    chk("kbd", 1, kbd_core_reset_o);
    wx(8'h2C, 8'h00);
    chk("kbd", 0, kbd_core_reset_o);
    config_mode_i = 1;
    for (i = 0; i < 8; i++) begin
      wx(8'h07, 8'(i));
      wx(8'h30, 8'(i % 2));
    end
    chk("act", 16'h00AA, {8'h00, unit_active_o});
    rx(8'h30, 8'h01);
    config_mode_i = 0;
    wx(8'h30, 8'h00);
    chk("act", 16'h00AA, {8'h00, unit_active_o});
    rx(8'h30, 8'h00);
    rx(8'h07, 8'h07);
    nb = 16'($random(seed));
    nb[15] = 1'b1; // keeps the new base clear of the old ports
    wx(8'h26, nb[7:0]);
    wx(8'h27, nb[15:8]);
    nb[0] = 1'b0;
    chk("base", nb, config_base_o);
    csc_host_inst.cyc(1'b0, 16'h002F, 8'h00);
    csc_host_inst.base = nb;
    rx(8'h26, nb[7:0]);
    {soft_rst_i, standby_supply_por_i} = 2'b11;
    @(posedge clk_i);
    #1 {soft_rst_i, standby_supply_por_i} = 0;
    chk("base", nb, config_base_o);
    {rst_i, cfg_strap_i} = 2'b11;
    repeat (3) @(posedge clk_i);
    #1 rst_i = 0;
    chk("base", 16'h004E, config_base_o);
    repeat (2) @(posedge clk_i);
    chk("queue", 16'h0000, 16'(q.size()));
    close_out;
  end
endmodule
bind csc_config_space csc_chk csc_chk_inst(
  .clk_i(clk_i), .rst_i(rst_i), .main_por_i(main_por_i),
  .standby_supply_por_i(standby_supply_por_i), .soft_rst_i(soft_rst_i),
  .config_mode_i(config_mode_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_hit_o(io_hit_o), .kbd_core_reset_o(kbd_core_reset_o), .io_addr_i(io_addr_i),
  .config_base_o(config_base_o), .unit_active_o(unit_active_o)
);
`default_nettype wire
